// [hw/mimx_consts.vh]
// Constants for the macro irq / mirror / mult / nop execution block.
// Assumes inclusion by bare name; definitions only.
`ifndef MIMX_CONSTS_VH
`define MIMX_CONSTS_VH

// Opcodes
`define MIMX_OP_MDIS        8'h34
`define MIMX_OP_MEN         8'h35
`define MIMX_OP_MIRROR      8'h2B
`define MIMX_OP_MULT        8'h24
`define MIMX_OP_NOP         8'h41
`define MIMX_OP_USER_OFF    8'h32
`define MIMX_OP_USER_ON     8'h33

// Cycle counts
`define MIMX_CYC_SHORT      5'd7
`define MIMX_CYC_LONG       5'd16
`define MIMX_CYC_MIRROR     5'd15
`define MIMX_CYC_MULT       5'd19
`define MIMX_CYC_NOP        5'd6
`define MIMX_CYC_OTHER      5'd6

// Instruction lengths
`define MIMX_LEN_1          8'h01
`define MIMX_LEN_2          8'h02
`define MIMX_LEN_3          8'h03

// Register map
`define MIMX_A_CTRL         8'h00
`define MIMX_A_STAT         8'h04
`define MIMX_A_PC           8'h08
`define MIMX_A_INSTR        8'h0C
`define MIMX_A_RAM          8'h10
`define MIMX_A_RAMDATA      8'h14
`define MIMX_A_UIRQ         8'h18

// Status bit positions
`define MIMX_ST_BUSY        0
`define MIMX_ST_GMASK       1
`define MIMX_ST_UOFF        2
`define MIMX_ST_ZERO        3
`define MIMX_ST_CARRY       4
`define MIMX_ST_SIGN        5

// Write field positions
`define MIMX_F_START        0
`define MIMX_F_IEN_LO       8
`define MIMX_F_PRE_Z        8
`define MIMX_F_PRE_C        9
`define MIMX_F_PRE_S        10

`endif

// [hw/mimx_exec.v]
// Execution of macro irq disable/enable, mirror, mult and nop.
// Assumes AHB-Lite single-word master; one clock hclk, reset hresetn.
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "mimx_consts.vh"
module mimx_exec #(
  parameter AW = 8
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [7:0]  irq_pending,
  output reg         irq_take,
  output reg         global_irq_mask,
  output reg         user_irq_off,
  output reg         busy
);
  // ==========================================================
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_RD1  = 3'b001;
  localparam [2:0] ST_WR1  = 3'b011;
  localparam [2:0] ST_WR2  = 3'b100;
  localparam [2:0] ST_WAIT = 3'b101;

  // ==========================================================
  // Bus address phase capture
  reg          dp_act;
  reg          dp_wr;
  reg [7:0]    dp_addr;
  reg [7:0]    ctrl_irq_en;
  reg [7:0]    pc;
  reg [23:0]   instr;
  reg [AW-1:0] ram_ptr;
  reg [2:0]    state;
  reg [4:0]    cnt;
  reg [4:0]    cyc_total;
  reg [7:0]    len;
  reg          flag_z;
  reg          flag_c;
  reg          flag_s;
  reg [7:0]    op;
  reg [7:0]    prod_lo;
  reg [7:0]    irq_sync1;
  reg [7:0]    irq_sync2;

  wire [7:0]   res_mirror;
  wire [15:0]  product;
  wire [7:0]   rd_a;
  wire [7:0]   rd_b;
  reg          ram_we;
  reg [AW-1:0] ram_waddr;
  reg [7:0]    ram_wdata;
  reg [AW-1:0] ra_a;
  reg [31:0]   stat_word;
  genvar       gi;

  wire addr_ok = hsel & htrans[1] & hready;
  wire go = dp_act & dp_wr & (dp_addr == `MIMX_A_CTRL) & hwdata[`MIMX_F_START] &
            (state == ST_IDLE);
  wire [7:0] opc = instr[7:0];
  wire [AW-1:0] arg1 = instr[8 +: AW];
  wire [AW-1:0] arg2 = instr[16 +: AW];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act    <= 1'b0;
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_act  <= addr_ok;
      dp_wr   <= hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // ==========================================================
  // Status word
  always @* begin
    stat_word                 = 32'h00000000;
    stat_word[`MIMX_ST_BUSY]  = busy;
    stat_word[`MIMX_ST_GMASK] = global_irq_mask;
    stat_word[`MIMX_ST_UOFF]  = user_irq_off;
    stat_word[`MIMX_ST_ZERO]  = flag_z;
    stat_word[`MIMX_ST_CARRY] = flag_c;
    stat_word[`MIMX_ST_SIGN]  = flag_s;
  end

  // ==========================================================
  // Read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `MIMX_A_CTRL:    hrdata <= {24'h000000, ctrl_irq_en};
        `MIMX_A_STAT:    hrdata <= stat_word;
        `MIMX_A_PC:      hrdata <= {24'h000000, pc};
        `MIMX_A_INSTR:   hrdata <= {8'h00, instr};
        `MIMX_A_RAM:     hrdata <= {{(32-AW){1'b0}}, ram_ptr};
        `MIMX_A_RAMDATA: hrdata <= {24'h000000, rd_b};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // RAM and datapath
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mirror
      assign res_mirror[gi] = rd_a[7-gi];
    end
  endgenerate
  assign product = rd_a * rd_b;

  mimx_ram #(.AW(AW)) u_ram (
    .hclk    (hclk),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr_a (ra_a),
    .rdata_a (rd_a),
    .raddr_b (state == ST_IDLE ? ram_ptr : arg2),
    .rdata_b (rd_b)
  );

  always @* begin
    ra_a      = arg1;
    ram_we    = 1'b0;
    ram_waddr = ram_ptr;
    ram_wdata = hwdata[7:0];
    if (dp_act && dp_wr && dp_addr == `MIMX_A_RAMDATA && state == ST_IDLE) begin
      ram_we = 1'b1;
    end else if (state == ST_WR1) begin
      ram_we    = 1'b1;
      ram_waddr = arg1;
      ram_wdata = (op == `MIMX_OP_MULT) ? product[15:8] : res_mirror;
    end else if (state == ST_WR2) begin
      ram_we    = 1'b1;
      ram_waddr = arg1 + {{(AW-1){1'b0}}, 1'b1};
      ram_wdata = prod_lo;
    end
  end

  // ==========================================================
  // Software registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_irq_en <= 8'h00;
      instr       <= 24'h000000;
      ram_ptr     <= {AW{1'b0}};
    end else if (dp_act && dp_wr) begin
      case (dp_addr)
        `MIMX_A_CTRL:  ctrl_irq_en <= hwdata[`MIMX_F_IEN_LO +: 8];
        `MIMX_A_INSTR: if (state == ST_IDLE) instr <= hwdata[23:0];
        `MIMX_A_RAM:   ram_ptr <= hwdata[AW-1:0];
        default:       ram_ptr <= ram_ptr;
      endcase
    end
  end

  // ==========================================================
  // Instruction sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state           <= ST_IDLE;
      cnt             <= 5'd0;
      cyc_total       <= 5'd0;
      len             <= 8'h00;
      op              <= 8'h00;
      pc              <= 8'h00;
      busy            <= 1'b0;
      flag_z          <= 1'b0;
      flag_c          <= 1'b0;
      flag_s          <= 1'b0;
      prod_lo         <= 8'h00;
      global_irq_mask <= 1'b0;
      user_irq_off    <= 1'b0;
    end else begin
      if (dp_act && dp_wr && dp_addr == `MIMX_A_UIRQ && state == ST_IDLE) begin
        flag_z <= hwdata[`MIMX_F_PRE_Z];
        flag_c <= hwdata[`MIMX_F_PRE_C];
        flag_s <= hwdata[`MIMX_F_PRE_S];
      end
      case (state)
        ST_IDLE: begin
          if (go) begin
            busy <= 1'b1;
            op   <= opc;
            cnt  <= 5'd1;
            state <= ST_WAIT;
            case (opc)
              `MIMX_OP_MDIS: begin
                cyc_total <= global_irq_mask ? `MIMX_CYC_LONG
                                             : `MIMX_CYC_SHORT;
                len <= `MIMX_LEN_1;
                global_irq_mask <= 1'b0;
              end
              `MIMX_OP_MEN: begin
                cyc_total <= global_irq_mask ? `MIMX_CYC_SHORT
                                             : `MIMX_CYC_LONG;
                len <= `MIMX_LEN_1;
                if (!user_irq_off) begin
                  global_irq_mask <= 1'b1;
                end
              end
              `MIMX_OP_MIRROR: begin
                cyc_total <= `MIMX_CYC_MIRROR;
                len   <= `MIMX_LEN_2;
                state <= ST_RD1;
              end
              `MIMX_OP_MULT: begin
                cyc_total <= `MIMX_CYC_MULT;
                len   <= `MIMX_LEN_3;
                state <= ST_RD1;
              end
              `MIMX_OP_USER_OFF: begin
                cyc_total       <= `MIMX_CYC_OTHER;
                len             <= `MIMX_LEN_1;
                user_irq_off    <= 1'b1;
                global_irq_mask <= 1'b0;
              end
              `MIMX_OP_USER_ON: begin
                cyc_total       <= `MIMX_CYC_OTHER;
                len             <= `MIMX_LEN_1;
                user_irq_off    <= 1'b0;
                global_irq_mask <= 1'b1;
              end
              default: begin
                cyc_total <= `MIMX_CYC_NOP;
                len       <= `MIMX_LEN_1;
              end
            endcase
          end
        end
        ST_RD1: begin
          cnt   <= cnt + 5'd1;
          state <= ST_WR1;
          prod_lo <= product[7:0];
          if (op == `MIMX_OP_MULT) begin
            flag_z <= (product == 16'h0000);
          end else begin
            flag_z <= (res_mirror == 8'h00);
          end
        end
        ST_WR1: begin
          cnt   <= cnt + 5'd1;
          state <= (op == `MIMX_OP_MULT) ? ST_WR2 : ST_WAIT;
        end
        ST_WR2: begin
          cnt   <= cnt + 5'd1;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt >= cyc_total) begin
            busy  <= 1'b0;
            pc    <= pc + len;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt + 5'd1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Interrupt gating
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_sync1 <= 8'h00;
      irq_sync2 <= 8'h00;
      irq_take  <= 1'b0;
    end else begin
      irq_sync1 <= irq_pending;
      irq_sync2 <= irq_sync1;
      irq_take  <= global_irq_mask & (|(irq_sync2 & ctrl_irq_en));
    end
  end
endmodule // mimx_exec

// [hw/mimx_ram.v]
// Core data RAM, one write port and two asynchronous read ports.
// Assumes single clock hclk; contents undefined after reset.
`timescale 1ns/1ps
module mimx_ram #(
  parameter AW = 8
) (
  input  wire          hclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [7:0]    wdata,
  input  wire [AW-1:0] raddr_a,
  output wire [7:0]    rdata_a,
  input  wire [AW-1:0] raddr_b,
  output wire [7:0]    rdata_b
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule // mimx_ram

// [sim/macro_irq_mirror_mult_nop_exec_test.sv]
// Bench: register tasks over AHB-Lite, then instruction sequences.
// Assumes zero wait states and the register map of the block.
`timescale 1ns/1ps
module macro_irq_mirror_mult_nop_exec_test;
  reg         hclk = 1'h0;
  reg         hresetn = 1'h0;
  reg         hsel = 1'h0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'h0;
  reg  [31:0] hwdata = 32'h0;
  reg  [7:0]  raise = 8'h0;
  reg  [7:0]  drop = 8'h0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] pc = 32'h0;
  reg  [31:0] d;
  wire [31:0] hrdata;
  wire [7:0]  irq_pending;
  wire        hreadyout, hresp, irq_take, global_irq_mask, user_irq_off, busy;
  integer     miscompares = 0;
  integer     tests_run = 0;
  // ==========================================
  // Design and interrupt sources
  mimx_exec uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pending(irq_pending),
    .irq_take(irq_take), .global_irq_mask(global_irq_mask), .user_irq_off(user_irq_off),
    .busy(busy));
  mimx_irq_src src (.hclk(hclk), .hresetn(hresetn), .raise(raise), .drop(drop),
    .irq_pending(irq_pending));
  initial forever #50 hclk = ~hclk;
  // ==========================================
  // Tasks
  task report_and_stop;
    begin
      $display("Compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task step;
    integer k;
    begin
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'h1) begin
        k = k + 1;
        if (k > 20) begin
          miscompares = miscompares + 1;
          report_and_stop;
        end
        @(posedge hclk);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    begin
      haddr <= a; hwrite <= 1'h1; hsel <= 1'h1; htrans <= 2'h2; step;
      htrans <= 2'h0; hsel <= 1'h0; hwdata <= v; step;
    end
  endtask
  task rd(input [31:0] a, output [31:0] v);
    begin
      haddr <= a; hwrite <= 1'h0; hsel <= 1'h1; htrans <= 2'h2; step;
      htrans <= 2'h0; hsel <= 1'h0; step;
      v = hrdata;
    end
  endtask
  task run(input [31:0] ins, input [31:0] cyc, input [31:0] len, input [31:0] st);
    integer n, k;
    begin
      wr(32'h0C, ins);
      wr(32'h00, 32'hFF01);
      n = 0; k = 0; #1;
      while (k < 100 && (n == 0 || busy === 1'h1)) begin
        if (busy === 1'h1) n = n + 1;
        @(posedge hclk); #1; k = k + 1;
      end
      if (k == 100) begin
        miscompares = miscompares + 1;
        report_and_stop;
      end
      @(posedge hclk);
      chk(n, cyc);
      pc = pc + len;
      rd(32'h08, d); chk(d, pc);
      rd(32'h04, d); chk(d, st);
      chk({hresp, user_irq_off, global_irq_mask}, {1'h0, st[2:1]});
    end
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    rd(32'h04, d); chk(d, 32'h0);
    wr(32'h18, 32'h600);
    run(32'h34, 7, 1, 32'h30);
    raise <= 8'h01; @(posedge hclk); raise <= 8'h00;
    run(32'h35, 16, 1, 32'h32);
    repeat (3) @(posedge hclk); chk(irq_take, 1'h1);
    drop <= 8'h01;
    @(posedge hclk);
    drop <= 8'h00;
    repeat (4) @(posedge hclk);
    chk(irq_take, 1'h0);
    raise <= 8'h01;
    @(posedge hclk);
    raise <= 8'h00;
    run(32'h35, 7, 1, 32'h32);
    run(32'h34, 16, 1, 32'h30);
    repeat (3) @(posedge hclk); chk(irq_take, 1'h0);
    wr(32'h10, 32'h18); wr(32'h14, 32'h8E);
    run(32'h182B, 15, 2, 32'h30);
    rd(32'h14, d); chk(d, 32'h71);
    wr(32'h14, 32'h0); run(32'h182B, 15, 2, 32'h38);
    run(32'h41, 6, 1, 32'h38);
    rd(32'h14, d); chk(d, 32'h0);
    wr(32'h10, 32'h14); wr(32'h14, 32'h64); wr(32'h10, 32'h28); wr(32'h14, 32'h1E);
    run(32'h281424, 19, 3, 32'h30);
    wr(32'h10, 32'h14); rd(32'h14, d); chk(d, 32'h0B);
    wr(32'h10, 32'h15); rd(32'h14, d); chk(d, 32'hB8);
    run(32'h32, 6, 1, 32'h34);
    run(32'h35, 16, 1, 32'h34);
    run(32'h33, 6, 1, 32'h32);
    report_and_stop;
  end
endmodule // macro_irq_mirror_mult_nop_exec_test

// [sim/mimx_exec_checker.sv]
// Checker on the execution block's interrupt and busy outputs.
// Assumes a bind onto mimx_exec; one clock hclk, reset hresetn.
`timescale 1ns/1ps
module mimx_exec_checker (
  input wire       hclk,
  input wire       hresetn,
  input wire [7:0] irq_pending,
  input wire       irq_take,
  input wire       global_irq_mask,
  input wire       user_irq_off,
  input wire       busy
);
  // ==========================================
  // Busy run length and properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg [5:0] run_len;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_len <= 6'h00;
    else run_len <= busy ? run_len + 6'h01 : 6'h00;
  end
  a_take_needs_mask: assert property (
    !global_irq_mask && !$past(global_irq_mask) |-> !irq_take)
    else $error("Interrupt taken while mask off");
  a_no_req_take: assert property ((irq_pending == 8'h00) [*4] |-> !irq_take)
    else $error("Interrupt taken with no request");
  a_mask_idle_hold: assert property (!busy && !$past(busy) |-> $stable(global_irq_mask))
    else $error("Mask moved while idle");
  a_uoff_blocks_enable: assert property (
    user_irq_off && $past(user_irq_off) |-> !$rose(global_irq_mask))
    else $error("Mask enabled under user disable");
  a_busy_max: assert property (run_len <= 6'h13)
    else $error("Instruction longer than 19 cycles");
  a_busy_min: assert property ($rose(busy) |-> busy [*6])
    else $error("Instruction shorter than 6 cycles");
  a_uoff_idle_hold: assert property (!busy && !$past(busy) |-> $stable(user_irq_off))
    else $error("User disable moved while idle");
  a_cycle_set: assert property (
    $fell(busy) |-> run_len inside {6'h06, 6'h07, 6'h0F, 6'h10, 6'h13})
    else $error("Instruction length not a legal count");
  c_mask_on: cover property ($rose(global_irq_mask));
  c_mask_off: cover property ($fell(global_irq_mask));
  c_take: cover property (irq_take);
  c_mult_len: cover property ($fell(busy) && run_len == 6'h13);
endmodule // mimx_exec_checker
bind mimx_exec mimx_exec_checker chk (.hclk, .hresetn, .irq_pending, .irq_take,
  .global_irq_mask, .user_irq_off, .busy);

// [sim/mimx_irq_src.sv]
// Interrupt sources: each request stays pending until dropped.
// Assumes the bench pulses raise and drop right after a rising edge.
`timescale 1ns/1ps
module mimx_irq_src (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire [7:0] raise,
  input  wire [7:0] drop,
  output reg  [7:0] irq_pending
);
  // ==========================================
  // Pending levels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_pending <= 8'h00;
    else irq_pending <= (irq_pending | raise) & ~drop;
  end
endmodule // mimx_irq_src
